// ===== nvc_cmd_port.sv
// command decoder, burst engine and array of the serial memory port
//
// Notes on behaviour
// - status read returns exactly one status byte, msb first
// - status write loads following byte into the two protect bits
// - write-protect pin low blocks status and array writes
// - completed status write clears the write latch at frame end
// - opcode bit 3 is address bit 8, next byte the low eight
// - data bytes go to incrementing addresses while clocks continue
// - burst address wraps from last address back to zero
// - write data arrives msb first
// - chip select rising ends an array write
// - burst hitting a protected address freezes address, drops data
// - each byte commits right after its eighth bit
// - partial bytes are never committed
// - after read address, data leaves over next eight clocks, sequential
// - serial input ignored while read data shifts out
// - chip select rising ends read and floats output; msb first
// - hold low pauses the transfer and keeps all its state
// - during hold, clock and chip select toggling are ignored
// - six opcodes decoded, memory opcodes carry address bit 8
// - latch set by set command, cleared at frame end after writes
// - protect codes give none, upper quarter, upper half, all
// - clock level at select falling picks mode 0 or mode 3
`timescale 1ns/1ps
`default_nettype none
`include "nvc_regs.svh"

module nvc_cmd_port (
   // system clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic CE_I,
   // serial link
   input wire logic SCK_I,
   input wire logic CS_N_I,
   input wire logic SI_I,
   input wire logic HOLD_N_I,
   input wire logic WP_N_I,
   output logic SO_O,
   output logic SO_OE_O,
   // device state
   output nvc_pkg::nvc_status_s STATUS_O
);

   import nvc_pkg::*;

   // =================================================================
   // system domain: pin synchronisers
   logic [3:0] pin_s;
   logic cs_n_s;
   logic sck_s;
   logic hold_n_s;
   logic wp_n_s;

   // reset to idle pin levels: select high, clock low, hold and wp high,
   // so no false select edge or mode capture follows reset
   nvc_sync #(
      .W(4),
      .RST(4'hb)
   ) u_pin_sync (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESETN_I),
      .ce_i(CE_I),
      .d_i({CS_N_I, SCK_I, HOLD_N_I, WP_N_I}),
      .q_o(pin_s)
   );

   assign cs_n_s = pin_s[3];
   assign sck_s = pin_s[2];
   assign hold_n_s = pin_s[1];
   assign wp_n_s = pin_s[0];

   // =================================================================
   // system domain: events and protect bits from the link
   logic set_tgl_r;
   logic clr_tgl_r;
   logic [1:0] bp_r;
   logic [3:0] lnk_s;
   logic set_tgl_s;
   logic clr_tgl_s;
   logic [1:0] bp_s;

   nvc_sync #(
      .W(4),
      .RST({2'h0, `NVC_BP_RST})
   ) u_lnk_sync (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESETN_I),
      .ce_i(CE_I),
      .d_i({set_tgl_r, clr_tgl_r, bp_r}),
      .q_o(lnk_s)
   );

   assign set_tgl_s = lnk_s[3];
   assign clr_tgl_s = lnk_s[2];
   assign bp_s = lnk_s[1:0];

   // =================================================================
   // system domain: write latch and mode detect
   logic cs_n_prev_r;
   logic set_prev_r;
   logic clr_prev_r;
   logic clr_pend_r;
   logic wel_r;
   logic mode3_r;
   logic set_ev;
   logic clr_ev;
   logic cs_rise;
   logic cs_fall;

   assign set_ev = set_tgl_s ^ set_prev_r;
   assign clr_ev = clr_tgl_s ^ clr_prev_r;
   assign cs_rise = cs_n_s & ~cs_n_prev_r & hold_n_s;
   assign cs_fall = ~cs_n_s & cs_n_prev_r & hold_n_s;

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cs_n_prev_r <= 1'b1;
         set_prev_r <= 1'b0;
         clr_prev_r <= 1'b0;
      end else if (CE_I) begin
         cs_n_prev_r <= cs_n_s;
         set_prev_r <= set_tgl_s;
         clr_prev_r <= clr_tgl_s;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         clr_pend_r <= 1'b0;
      end else if (CE_I) begin
         if (cs_rise) begin
            clr_pend_r <= 1'b0;
         end else if (clr_ev) begin
            clr_pend_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wel_r <= `NVC_WEL_RST;
      end else if (CE_I) begin
         // a set arriving with the clear wins
         if (set_ev) begin
            wel_r <= 1'b1;
         end else if (cs_rise && (clr_pend_r || clr_ev)) begin
            wel_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         mode3_r <= `NVC_MODE3_RST;
      end else if (CE_I && cs_fall) begin
         mode3_r <= sck_s;
      end
   end

   assign STATUS_O = '{mode3: mode3_r, bp_hi: bp_s[1], bp_lo: bp_s[0],
                       write_latch_flag: wel_r};

   // =================================================================
   // link domain: latch and write-protect seen on the serial clock
   logic [1:0] lvl_l;
   logic wel_l;
   logic wp_ok_l;

   nvc_sync #(
      .W(2),
      .RST({`NVC_WEL_RST, 1'b0})
   ) u_lvl_sync (
      .clk_i(SCK_I),
      .rst_n_i(RESETN_I),
      .ce_i(1'b1),
      .d_i({wel_r, wp_n_s}),
      .q_o(lvl_l)
   );

   assign wel_l = lvl_l[1];
   assign wp_ok_l = lvl_l[0];

   // =================================================================
   // link domain: frame state, cleared by select high outside hold
   nvc_phase_e phase_r;
   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   nvc_addr_t addr_r;
   nvc_byte_t tx_r;
   logic tx_live_r;
   logic stop_r;
   nvc_byte_t mem_r [0:`NVC_MEM_DEPTH-1];
   logic frame_rst_n;
   logic adv;
   logic byte_done;
   nvc_byte_t rx_byte;
   nvc_byte_t stat_byte;
   nvc_addr_t rx_addr;
   logic op_rd;
   logic op_wr;
   logic wr_ok;
   logic prot;

   assign frame_rst_n = RESETN_I & ~(CS_N_I & HOLD_N_I);
   assign adv = HOLD_N_I;
   assign byte_done = adv & (bit_cnt_r == 3'd7);
   assign rx_byte = {shift_r, SI_I};
   assign rx_addr = {addr_r[8], rx_byte};
   assign op_rd = (rx_byte[7:4] == `NVC_OP_HI_NIB) &&
                  (rx_byte[2:0] == `NVC_OP_MEM_RD_LO);
   assign op_wr = (rx_byte[7:4] == `NVC_OP_HI_NIB) &&
                  (rx_byte[2:0] == `NVC_OP_MEM_WR_LO);
   assign wr_ok = wel_l & wp_ok_l;

   always_comb begin
      case (bp_r)
         `NVC_BP_QTR: prot = (addr_r >= `NVC_QTR_BASE);
         `NVC_BP_HALF: prot = (addr_r >= `NVC_HALF_BASE);
         `NVC_BP_ALL: prot = 1'b1;
         default: prot = 1'b0;
      endcase
   end

   always_comb begin
      stat_byte = 8'h00;
      stat_byte[`NVC_SR_WEL_BIT] = wel_l;
      stat_byte[`NVC_SR_BP_LO_BIT] = bp_r[0];
      stat_byte[`NVC_SR_BP_HI_BIT] = bp_r[1];
   end

   always_ff @(posedge SCK_I or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         phase_r <= PH_CMD;
         bit_cnt_r <= 3'd0;
         shift_r <= 7'h00;
         addr_r <= 9'h000;
         tx_r <= 8'h00;
         tx_live_r <= 1'b0;
         stop_r <= 1'b0;
      end else if (adv) begin
         bit_cnt_r <= bit_cnt_r + 3'd1;
         if (phase_r != PH_RDATA && phase_r != PH_SREAD) begin
            shift_r <= rx_byte[6:0];
         end
         case (phase_r)
            PH_CMD: begin
               if (byte_done) begin
                  addr_r[8] <= rx_byte[`NVC_OP_A8_BIT];
                  if (rx_byte == `NVC_OP_STAT_RD) begin
                     phase_r <= PH_SREAD;
                     tx_r <= stat_byte;
                     tx_live_r <= 1'b1;
                  end else if (rx_byte == `NVC_OP_STAT_WR) begin
                     phase_r <= PH_SWDATA;
                  end else if (op_rd) begin
                     phase_r <= PH_ADDR_RD;
                  end else if (op_wr) begin
                     phase_r <= PH_ADDR_WR;
                  end else begin
                     phase_r <= PH_IGNORE;
                  end
               end
            end
            PH_ADDR_RD: begin
               if (byte_done) begin
                  tx_r <= mem_r[rx_addr];
                  tx_live_r <= 1'b1;
                  addr_r <= rx_addr + 9'h001;
                  phase_r <= PH_RDATA;
               end
            end
            PH_ADDR_WR: begin
               if (byte_done) begin
                  addr_r <= rx_addr;
                  phase_r <= PH_WDATA;
               end
            end
            PH_RDATA: begin
               if (byte_done) begin
                  tx_r <= mem_r[addr_r];
                  addr_r <= addr_r + 9'h001;
               end else begin
                  tx_r <= {tx_r[6:0], 1'b0};
               end
            end
            PH_WDATA: begin
               if (byte_done && !stop_r) begin
                  if (prot) begin
                     stop_r <= 1'b1;
                  end else begin
                     addr_r <= addr_r + 9'h001;
                  end
               end
            end
            PH_SREAD: begin
               if (byte_done) begin
                  tx_live_r <= 1'b0;
                  phase_r <= PH_IGNORE;
               end else begin
                  tx_r <= {tx_r[6:0], 1'b0};
               end
            end
            PH_SWDATA: begin
               if (byte_done) begin
                  phase_r <= PH_IGNORE;
               end
            end
            default: begin
               phase_r <= PH_IGNORE;
            end
         endcase
      end
   end

   // =================================================================
   // link domain: array, protect bits, events toward the system side
   // commit at eighth bit
   always_ff @(posedge SCK_I) begin
      if (adv && byte_done && phase_r == PH_WDATA && !stop_r &&
          !prot && wr_ok && frame_rst_n) begin
         mem_r[addr_r] <= rx_byte;
      end
   end

   always_ff @(posedge SCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bp_r <= `NVC_BP_RST;
      end else if (byte_done && phase_r == PH_SWDATA && wr_ok &&
                   frame_rst_n) begin
         bp_r <= {rx_byte[`NVC_SR_BP_HI_BIT], rx_byte[`NVC_SR_BP_LO_BIT]};
      end
   end

   // toggles outlive the frame, so only the system reset clears them
   // set and clear requests
   always_ff @(posedge SCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         set_tgl_r <= 1'b0;
         clr_tgl_r <= 1'b0;
      end else if (byte_done && phase_r == PH_CMD && frame_rst_n) begin
         if (rx_byte == `NVC_OP_SET_LATCH) begin
            set_tgl_r <= ~set_tgl_r;
         end
         if (rx_byte == `NVC_OP_CLR_LATCH || rx_byte == `NVC_OP_STAT_WR ||
             op_wr) begin
            clr_tgl_r <= ~clr_tgl_r;
         end
      end
   end

   // =================================================================
   // link domain: output launched on the falling clock edge
   logic so_r;
   logic so_oe_r;

   always_ff @(negedge SCK_I or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
      end else if (adv) begin
         // mode 3 leading fall finds tx idle, so nothing leaks out
         so_r <= tx_r[7];
         so_oe_r <= tx_live_r;
      end
   end

   assign SO_O = so_r;
   assign SO_OE_O = so_oe_r & HOLD_N_I;

endmodule : nvc_cmd_port

`default_nettype wire

// ===== nvc_cmd_port_asserts.sv
// assertion checker of the serial memory command port
`timescale 1ns/1ps
`default_nettype none

module nvc_cmd_port_asserts (
   // clocks and reset
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic SCK_I,
   // link and state
   input wire logic CS_N_I,
   input wire logic SI_I,
   input wire logic HOLD_N_I,
   input wire logic WP_N_I,
   input wire logic SO_OE_O,
   input wire nvc_pkg::nvc_status_s STATUS_O
);
   import nvc_pkg::*;
   // ==========
   // link decode, cleared like the port's frame
   logic clr;
   logic op_unk;
   logic [4:0] bit_cnt;
   logic [4:0] since_cs;
   logic [7:0] sh;
   logic [7:0] op;
   logic [7:0] wp_cnt;
   assign clr = (CS_N_I && HOLD_N_I) || !RESETN_I;
   assign op_unk = !(op inside {8'h06, 8'h04, 8'h05, 8'h01}) &&
      !(op[7:4] == 4'h0 && op[2:1] == 2'h1);
   always_ff @(posedge SCK_I or posedge clr) begin
      if (clr) begin
         bit_cnt <= 5'h00;
      end else if (HOLD_N_I && bit_cnt != 5'h1f) begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end
   always_ff @(posedge SCK_I or posedge clr) begin
      if (clr) begin
         sh <= 8'h00;
         op <= 8'h00;
      end else if (HOLD_N_I) begin
         sh <= {sh[6:0], SI_I};
         op <= (bit_cnt == 5'h07) ? {sh[6:0], SI_I} : op;
      end
   end
   // saturating, so long idle spans do not wrap
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         since_cs <= 5'h00;
         wp_cnt <= 8'h00;
      end else begin
         since_cs <= CS_N_I ? 5'h00 : since_cs + {4'h0, since_cs != 5'h1f};
         wp_cnt <= WP_N_I ? 8'h00 : wp_cnt + {7'h0, wp_cnt != 8'hff};
      end
   end
   sequence s_stat_out;
      SO_OE_O [*8] ##1 !SO_OE_O;
   endsequence
   sequence s_quiet;
      !SO_OE_O [*8];
   endsequence
   property p_oe_hold;
      @(posedge SYS_CLK_I) disable iff (!RESETN_I) !HOLD_N_I |-> !SO_OE_O;
   endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("output enabled during hold");
   property p_oe_cs;
      @(posedge SYS_CLK_I) disable iff (!RESETN_I)
         CS_N_I && HOLD_N_I |-> !SO_OE_O;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("output enabled while deselected");
   property p_oe_rise;
      @(posedge SYS_CLK_I) disable iff (!RESETN_I) $rose(SO_OE_O) |-> !SCK_I;
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("output enabled off the falling clock");
   property p_bp_wp;
      @(posedge SYS_CLK_I) disable iff (!RESETN_I)
         wp_cnt == 8'hff |-> $stable({STATUS_O.bp_hi, STATUS_O.bp_lo});
   endproperty
   a_bp_wp: assert property (p_bp_wp)
      else $error("protect bits changed with pin low");
   property p_wel_fall;
      @(posedge SYS_CLK_I) disable iff (!RESETN_I)
         $fell(STATUS_O.write_latch_flag) |-> since_cs <= 5'h04;
   endproperty
   a_wel_fall: assert property (p_wel_fall)
      else $error("latch cleared away from a deselect");
   property p_mode;
      @(posedge SYS_CLK_I) disable iff (!RESETN_I) $changed(STATUS_O.mode3)
         |-> since_cs != 5'h00 && since_cs <= 5'h18;
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode changed away from a select");
   property p_sread;
      @(posedge SCK_I) disable iff (!RESETN_I || !HOLD_N_I)
         bit_cnt == 5'h08 && op == 8'h05 |-> s_stat_out;
   endproperty
   a_sread: assert property (p_sread)
      else $error("status byte length wrong");
   property p_rd_start;
      @(posedge SCK_I) disable iff (!RESETN_I || !HOLD_N_I)
         bit_cnt == 5'h10 && op[7:4] == 4'h0 && op[2:0] == 3'h3 |-> SO_OE_O;
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read data not driven after address");
   property p_unknown;
      @(posedge SCK_I) disable iff (!RESETN_I || !HOLD_N_I)
         bit_cnt == 5'h08 && op_unk |-> s_quiet;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("output driven after unknown opcode");
endmodule : nvc_cmd_port_asserts

bind nvc_cmd_port nvc_cmd_port_asserts nvc_cmd_port_asserts_i (
   .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SCK_I(SCK_I),
   .CS_N_I(CS_N_I), .SI_I(SI_I), .HOLD_N_I(HOLD_N_I), .WP_N_I(WP_N_I),
   .SO_OE_O(SO_OE_O), .STATUS_O(STATUS_O));

`default_nettype wire

// ===== nvc_pkg.sv
// types shared by the serial nonvolatile memory command port
`default_nettype none

package nvc_pkg;

   typedef logic [8:0] nvc_addr_t;
   typedef logic [7:0] nvc_byte_t;

   // =================================================================
   // transfer phase inside one chip-select frame
   typedef enum logic [2:0] {
      PH_CMD,
      PH_ADDR_RD,
      PH_ADDR_WR,
      PH_RDATA,
      PH_WDATA,
      PH_SREAD,
      PH_SWDATA,
      PH_IGNORE
   } nvc_phase_e;

   // =================================================================
   // visible device state
   typedef struct packed {
      logic mode3;
      logic bp_hi;
      logic bp_lo;
      logic write_latch_flag;
   } nvc_status_s;

endpackage : nvc_pkg

`default_nettype wire

// ===== nvc_regs.svh
// constants of the serial nonvolatile memory command port
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

// =====================================================================
// opcodes
`define NVC_OP_SET_LATCH 8'h06
`define NVC_OP_CLR_LATCH 8'h04
`define NVC_OP_STAT_RD 8'h05
`define NVC_OP_STAT_WR 8'h01
`define NVC_OP_HI_NIB 4'h0
`define NVC_OP_MEM_RD_LO 3'h3
`define NVC_OP_MEM_WR_LO 3'h2
`define NVC_OP_A8_BIT 3

// =====================================================================
// status byte layout and reset values
`define NVC_SR_WEL_BIT 1
`define NVC_SR_BP_LO_BIT 2
`define NVC_SR_BP_HI_BIT 3
`define NVC_WEL_RST 1'b0
`define NVC_BP_RST 2'h0
`define NVC_MODE3_RST 1'b0

// =====================================================================
// array geometry and protected region bases
`define NVC_MEM_DEPTH 512
`define NVC_QTR_BASE 9'h180
`define NVC_HALF_BASE 9'h100
`define NVC_BP_NONE 2'h0
`define NVC_BP_QTR 2'h1
`define NVC_BP_HALF 2'h2
`define NVC_BP_ALL 2'h3

`endif

// ===== nvc_spi_master.sv
// serial bus master model driving the memory port's link pins
`timescale 1ns/1ps
`default_nettype none

module nvc_spi_master (
   // link pins toward the port
   output var logic sck_o,
   output var logic cs_n_o,
   output var logic si_o,
   output var logic hold_n_o,
   // answer from the port
   input wire logic so_i,
   input wire logic so_oe_i
);
   logic mode3 = 1'b0;
   logic oe_any = 1'b0;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end
   // ==========
   // frames; clock stands at the mode level between them
   task automatic cs_lo();
      sck_o = mode3;
      #23;
      cs_n_o = 1'b0;
      oe_any = 1'b0;
      #32;
   endtask : cs_lo
   task automatic cs_hi();
      #16;
      sck_o = mode3;
      #16;
      cs_n_o = 1'b1;
      // released line must not keep the last bit
      si_o = ~si_o;
      #100;
   endtask : cs_hi
   task automatic bx(input logic [7:0] tx, input int nb, input int hold_at,
                     output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < nb; i++) begin
         sck_o = 1'b0;
         si_o = tx[7-i];
         #32;
         if (i == hold_at) begin
            // hold moves only with clock low
            hold_n_o = 1'b0;
            repeat (3) begin
               #8 sck_o = 1'b1;
               #8 sck_o = 1'b0;
            end
            #8 cs_n_o = 1'b1;
            #8 cs_n_o = 1'b0;
            #8 hold_n_o = 1'b1;
            #8;
         end
         sck_o = 1'b1;
         rx = {rx[6:0], so_i};
         oe_any = oe_any | so_oe_i;
         #32;
      end
   endtask : bx
endmodule : nvc_spi_master

`default_nettype wire

// ===== nvc_sync.sv
// three-stage synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module nvc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               s1_r[g] <= RST[g];
               s2_r[g] <= RST[g];
               s3_r[g] <= RST[g];
               q_r[g] <= RST[g];
            end else if (ce_i) begin
               s1_r[g] <= d_i[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               // a single-stage glitch never reaches the output
               if (s2_r[g] == s3_r[g]) begin
                  q_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   assign q_o = q_r;

endmodule : nvc_sync

`default_nettype wire

// ===== test_spi_nvram_command_port.sv
// self-checking bench of the serial memory command port
`timescale 1ns/1ps
`default_nettype none

module test_spi_nvram_command_port;
   import nvc_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic wp_n = 1'b1;
   wire logic sck, cs_n, si, hold_n, so, so_oe;
   nvc_status_s status;
   int failures = 0;
   int n_checks = 0;
   logic wel_x = 1'b0;
   logic [1:0] bp_x = 2'h0;
   logic [7:0] mem_x [0:511];
   logic [7:0] rx;
   logic [7:0] odd [0:3] = '{8'h84, 8'h0d, 8'h87, 8'hff};

   always #2 sys_clk = ~sys_clk;

   nvc_spi_master nvc_spi_master_i (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
      .hold_n_o(hold_n), .so_i(so), .so_oe_i(so_oe));
   nvc_cmd_port nvc_cmd_port_i (.SYS_CLK_I(sys_clk), .RESETN_I(resetn),
      .CE_I(1'b1), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .HOLD_N_I(hold_n),
      .WP_N_I(wp_n), .SO_O(so), .SO_OE_O(so_oe), .STATUS_O(status));

   // ==========
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic b(input logic [7:0] t);
      nvc_spi_master_i.bx(t, 8, -1, rx);
   endtask : b
   task automatic set_wp(input logic v);
      @(posedge sys_clk);
      #1 wp_n = v;
   endtask : set_wp
   function automatic logic prot(input logic [8:0] a);
      return bp_x == 2'h3 || (bp_x == 2'h2 && a[8]) ||
         (bp_x == 2'h1 && a[8:7] == 2'h3);
   endfunction : prot
   task automatic op1(input logic [7:0] op, input int n);
      nvc_spi_master_i.cs_lo();
      b(op);
      repeat (n) b(8'h06);
      nvc_spi_master_i.cs_hi();
      if (op == 8'h06) wel_x = 1'b1;
      if (op == 8'h04) wel_x = 1'b0;
   endtask : op1
   task automatic status_read_cmd();
      nvc_spi_master_i.cs_lo();
      b(8'h05);
      b(8'h00);
      nvc_spi_master_i.cs_hi();
      check(rx, {4'h0, bp_x, wel_x, 1'b0});
      check({4'h0, status}, {4'h0, nvc_spi_master_i.mode3, bp_x, wel_x});
   endtask : status_read_cmd
   task automatic status_write_cmd(input logic [7:0] v);
      nvc_spi_master_i.cs_lo();
      b(8'h01);
      b(v);
      nvc_spi_master_i.cs_hi();
      // needs latch and pin, clears latch
      if (wel_x && wp_n) bp_x = v[3:2];
      wel_x = 1'b0;
   endtask : status_write_cmd
   task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0,
                     input logic part);
      logic stop;
      logic [7:0] d;
      stop = 1'b0;
      nvc_spi_master_i.cs_lo();
      b({4'h0, a[8], 3'h2});
      b(a[7:0]);
      for (int i = 0; i < n; i++) begin
         d = d0 + 8'(i);
         b(d);
         if (wel_x && wp_n && !stop) begin
            stop = prot(a);
            if (!stop) mem_x[a] = d;
         end
         if (!stop) a = a + 9'h001;
      end
      if (part) nvc_spi_master_i.bx(8'h3c, 5, -1, rx);
      nvc_spi_master_i.cs_hi();
      wel_x = 1'b0;
   endtask : wr
   task automatic rd(input logic [8:0] a, input int n, input int h);
      nvc_spi_master_i.cs_lo();
      b({4'h0, a[8], 3'h3});
      b(a[7:0]);
      for (int i = 0; i < n; i++) begin
         // noise on the input line while data shifts out
         nvc_spi_master_i.bx(8'ha5, 8, i == 0 ? h : -1, rx);
         check(rx, mem_x[a + 9'(i)]);
      end
      nvc_spi_master_i.cs_hi();
   endtask : rd

   initial begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      close_out();
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      #1 resetn = 1'b1;
      repeat (8) @(posedge sys_clk);
      status_read_cmd();
      op1(8'h06, 0);
      status_read_cmd();
      op1(8'h04, 0);
      status_read_cmd();
      $display("test latch done");
      // latch set in its own frame before the first two writes; the third runs with it clear
      op1(8'h06, 0);
      wr(9'h1fe, 5, 8'h10, 1'b0);
      op1(8'h06, 0);
      wr(9'h1fe, 4, 8'h20, 1'b1);
      wr(9'h000, 2, 8'h30, 1'b0);
      rd(9'h1fe, 5, -1);
      $display("test burst done");
      set_wp(1'b0);
      op1(8'h06, 0);
      wr(9'h1fe, 2, 8'h40, 1'b0);
      // status write tried with pin low
      op1(8'h06, 0);
      status_write_cmd(8'h0c);
      status_read_cmd();
      rd(9'h1fe, 2, -1);
      set_wp(1'b1);
      $display("test pin done");
      for (int c = 0; c < 4; c++) begin
         op1(8'h06, 0);
         status_write_cmd({4'h0, 2'(c), 2'h0});
         status_read_cmd();
         op1(8'h06, 0);
         wr(9'h0ff, 2, {4'h5, 2'(c), 2'h0}, 1'b0);
         op1(8'h06, 0);
         wr(9'h17f, 2, {4'h6, 2'(c), 2'h0}, 1'b0);
         rd(9'h0ff, 2, 3);
         rd(9'h17f, 2, -1);
      end
      $display("test protect done");
      op1(8'h06, 0);
      for (int k = 0; k < 4; k++) begin
         op1(odd[k], 2);
         check({7'h0, nvc_spi_master_i.oe_any}, 8'h00);
      end
      status_read_cmd();
      $display("test opcode done");
      nvc_spi_master_i.mode3 = 1'b1;
      status_read_cmd();
      rd(9'h1fe, 5, -1);
      nvc_spi_master_i.mode3 = 1'b0;
      status_read_cmd();
      $display("test mode done");
      close_out();
   end
endmodule : test_spi_nvram_command_port

`default_nettype wire
